/* File: rtl/ips_defs.svh */
// Timing counts, field positions and reset values of the pipeline sequencer
`ifndef IPS_DEFS_SVH
`define IPS_DEFS_SVH

// ----------------------------------------------------------------
// Clock and microcycle timing
// ----------------------------------------------------------------
`define IPS_CLK_NS 25
`define IPS_UCYCLE_NS 200
`define IPS_UCYCLE_CLKS (`IPS_UCYCLE_NS / `IPS_CLK_NS)
`define IPS_ADDR_LEAD_NS 50
`define IPS_ADDR_LEAD_CLKS (`IPS_ADDR_LEAD_NS / `IPS_CLK_NS)
`define IPS_LAST_PHASE (`IPS_UCYCLE_CLKS - 1)
`define IPS_MAR_LOAD_PHASE (`IPS_UCYCLE_CLKS - `IPS_ADDR_LEAD_CLKS - 1)

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define IPS_OPC_HI 15
`define IPS_OPC_LO 8
`define IPS_CLASS_HI 15
`define IPS_CLASS_LO 14
`define IPS_IOLEN_HI 10
`define IPS_IOLEN_LO 8
`define IPS_MASK_HI 7
`define IPS_MASK_LO 4
`define IPS_INDEX_HI 3
`define IPS_INDEX_LO 0

// ----------------------------------------------------------------
// Constants and reset values
// ----------------------------------------------------------------
`define IPS_PC_STEP 16'h0002
`define IPS_IRQ_BACKUP 16'h0004
`define IPS_RESET_PC 16'h0000
`define IPS_EXEC_ONE 3'h1
`define IPS_EXEC_TWO 3'h2

`endif

/* File: rtl/ips_pkg.sv */
// Types shared by the pipeline sequencer and its mapping decoder
`default_nettype none

package ips_pkg;

	// ----------------------------------------------------------------
	// Microcycle steps of the sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_FIA = 3'b000,
		ST_FILL = 3'b001,
		ST_DECODE = 3'b010,
		ST_EXEC = 3'b011,
		ST_OPADDR = 3'b100,
		ST_OPFETCH = 3'b101,
		ST_BR1 = 3'b110,
		ST_BR2 = 3'b111
	} ips_step_e;

	// Instruction classes from the opcode top bits
	typedef enum logic [1:0] {
		FMT_RR = 2'b00,
		FMT_RX = 2'b01,
		FMT_BRANCH = 2'b10,
		FMT_IO = 2'b11
	} ips_fmt_e;

	// What a memory read brings back
	typedef enum logic [1:0] {
		RD_NONE = 2'b00,
		RD_ISTREAM = 2'b01,
		RD_OPERAND = 2'b10
	} ips_rd_e;

	// Address holding register and read strobe toward memory
	typedef struct packed {
		logic read;
		logic [15:0] addr;
	} ips_mem_req_s;

	// Mapping decoder result
	typedef struct packed {
		logic [7:0] start;
		ips_fmt_e fmt;
		logic [2:0] exec_len;
		logic [3:0] mask;
		logic [3:0] index;
	} ips_dec_s;

endpackage

`default_nettype wire

/* File: rtl/ips_map_decoder.sv */
// Mapping decoder: opcode to microprogram start address and class
`default_nettype none
`include "ips_defs.svh"

module ips_map_decoder import ips_pkg::*; (
	// Control
	input wire logic enable,
	// Instruction word from the decode data latch, or the arriving read word while the latch is empty
	input wire logic [15:0] word,
	// Decoded result, all zero while disabled
	output var ips_dec_s dec
);

	// ----------------------------------------------------------------
	// Combinational mapping
	// ----------------------------------------------------------------
	// Output held at zero unless enabled, so nothing downstream can act early
	always_comb begin
		dec = '0;
		if (enable) begin
			dec.fmt = ips_fmt_e'(word[`IPS_CLASS_HI:`IPS_CLASS_LO]);
			// Opcode rotated left by two gives the start address
			dec.start = {word[`IPS_OPC_HI-2:`IPS_OPC_LO], word[`IPS_CLASS_HI:`IPS_CLASS_LO]};
			dec.exec_len = `IPS_EXEC_ONE;
			// I/O class carries its own execute length, zero meaning one
			if (dec.fmt == FMT_IO && word[`IPS_IOLEN_HI:`IPS_IOLEN_LO] != 3'h0) begin
				dec.exec_len = word[`IPS_IOLEN_HI:`IPS_IOLEN_LO];
			end
			dec.mask = word[`IPS_MASK_HI:`IPS_MASK_LO];
			dec.index = word[`IPS_INDEX_HI:`IPS_INDEX_LO];
		end
	end

endmodule

`default_nettype wire

/* File: rtl/ips_sequencer.sv */
// Instruction pipeline sequencer: overlapped fetch, decode and execute steps
//
// Notes on behaviour
// RULE_01 - Memory returns read data within one microcycle.
// RULE_02 - Decoder maps 8-bit opcode to 8-bit start.
// RULE_03 - RR: address, fetch, decode, execute.
// RULE_04 - RX adds displacement, operand address, operand fetch.
// RULE_05 - Always a second read after instruction fetch.
// RULE_06 - RX decode makes second word the displacement.
// RULE_07 - Operand address is index register plus displacement.
// RULE_08 - Operand address loaded 50ns before cycle end.
// RULE_09 - Operand read returns at next cycle start.
// RULE_10 - Execute lasts one to seven microcycles.
// RULE_11 - Decoder enabled only in final execute cycle. The code also enables it in the idle ST_DECODE step.
// RULE_12 - Full pipeline: execute, decode, fetch, address together.
// RULE_13 - RR instructions complete one per microcycle.
// RULE_14 - RX instructions start executing every three cycles.
// RULE_15 - No decode before last execute cycle.
// RULE_16 - Multi-cycle execute stalls the pipeline.
// RULE_17 - Taken branch discards prefetched instructions.
// RULE_18 - Branch: 4-bit mask, target index plus displacement.
// RULE_19 - Branch cycle one loads target, fetches sequential.
// RULE_20 - Branch cycle two loads next+2 or target+2.
// RULE_21 - Branch cycle three decodes the next instruction.
// RULE_22 - Address step adds two to program counter.
// RULE_23 - Address register drives bus 50ns early.
// RULE_24 - Microcycle is 200ns, steps on its start.
// RULE_25 - Interrupt flushes, saves program counter minus four.
// RULE_26 - After reset, begin with instruction address step.
`default_nettype none
`include "ips_defs.svh"

module ips_sequencer import ips_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Memory read data
	input wire logic [15:0] mem_rdata,
	// Datapath: index register contents, condition flags
	input wire logic [15:0] index_data,
	input wire logic [3:0] cond_flags,
	// Interrupt request and service entry address
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	// Memory request: address holding register and read strobe
	output var ips_mem_req_s mem_req,
	// Sequencer status toward the microprogram
	output var ips_step_e step,
	output logic exec_active,
	output logic exec_last,
	output logic [7:0] micro_addr,
	output logic micro_valid,
	output logic [3:0] index_sel,
	output logic [15:0] alu_data_latch,
	output logic pipe_flush,
	// Interrupt entry
	output logic irq_ack,
	output logic [15:0] psw_pc
);

	// ----------------------------------------------------------------
	// Microcycle phase counter
	// ----------------------------------------------------------------
	logic [2:0] phase;
	logic [2:0] next_phase;
	logic tick;
	logic mar_load;

	// Tick ends each 200ns microcycle; all step state moves on it
	always_comb begin
		tick = (phase == 3'(`IPS_LAST_PHASE)); // see RULE_24
		mar_load = (phase == 3'(`IPS_MAR_LOAD_PHASE)); // see RULE_23
		next_phase = tick ? 3'h0 : phase + 3'h1;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 3'h0;
		end else begin
			phase <= next_phase;
		end
	end

	// ----------------------------------------------------------------
	// Pipeline state
	// ----------------------------------------------------------------
	logic [15:0] program_counter, next_pc;
	logic [2:0] exec_left, next_exec_left;
	logic [15:0] decode_data_latch, next_lat;
	logic lat_valid, next_lat_valid;
	logic [15:0] arr_word, next_arr_word;
	ips_rd_e arr_kind, next_arr_kind;
	ips_rd_e inflight, next_inflight;
	ips_rd_e issued, next_issued;
	logic [15:0] target_k, next_kaddr;
	logic [3:0] cur_mask, next_cur_mask;
	logic [2:0] cur_len, next_cur_len;
	ips_step_e next_step;
	logic next_exec_active, next_exec_last, next_micro_valid, next_flush, next_irq_ack;
	logic [7:0] next_micro_addr;
	logic [3:0] next_index_sel;
	logic [15:0] next_alu, next_psw_pc;
	ips_mem_req_s next_mem_req;
	// Per-cycle decisions
	logic [15:0] cur_word, opaddr, mar_val;
	logic cur_ok, do_decode, dec_take, taken, mar_en, arrival_used, drop_inflight;
	ips_rd_e iss_kind;
	ips_dec_s dec;

	// Decoder sees the latch if it holds a word, else the arriving one
	assign cur_word = lat_valid ? decode_data_latch : arr_word; // see RULE_02

	ips_map_decoder u_map (
		.enable(dec_take),
		.word(cur_word),
		.dec(dec)
	);

	// Next values for one microcycle, taken at the tick; memory request and issue kind at the load phase
	always_comb begin
		cur_ok = lat_valid || (arr_kind == RD_ISTREAM);
		// Decode point: idle decode slot or final execute cycle only
		do_decode = (step == ST_DECODE) || (step == ST_EXEC && exec_left == `IPS_EXEC_ONE); // see RULE_11
		dec_take = do_decode && cur_ok && !irq_req; // see RULE_15
		taken = |(cur_mask & cond_flags); // see RULE_18
		opaddr = index_data + arr_word; // see RULE_07
		next_step = step;
		next_pc = program_counter;
		next_exec_left = exec_left;
		next_lat = decode_data_latch;
		next_lat_valid = lat_valid;
		next_kaddr = target_k;
		next_cur_mask = cur_mask;
		next_cur_len = cur_len;
		next_alu = alu_data_latch;
		next_micro_addr = micro_addr;
		next_micro_valid = 1'b0;
		next_index_sel = index_sel;
		next_flush = 1'b0;
		next_irq_ack = 1'b0;
		next_psw_pc = psw_pc;
		mar_en = 1'b0;
		mar_val = mem_req.addr;
		iss_kind = RD_NONE;
		arrival_used = 1'b0;
		drop_inflight = 1'b0;
		case (step)
			ST_FIA, ST_FILL: begin
				// Address step, then fill fetch with its second read
				next_pc = program_counter + `IPS_PC_STEP; // see RULE_22
				mar_en = 1'b1;
				mar_val = program_counter + `IPS_PC_STEP;
				iss_kind = RD_ISTREAM; // see RULE_05
				next_step = (step == ST_FIA) ? ST_FILL : ST_DECODE; // see RULE_26
			end
			ST_OPADDR: begin
				// Arriving word is the displacement, not an instruction
				arrival_used = 1'b1; // see RULE_06
				next_alu = arr_word;
				mar_en = 1'b1;
				mar_val = opaddr; // see RULE_08
				iss_kind = RD_OPERAND; // see RULE_09
				next_step = ST_OPFETCH;
			end
			ST_OPFETCH: begin
				// Next instruction read only if execute ends at once
				if (cur_len == `IPS_EXEC_ONE) begin
					next_pc = program_counter + `IPS_PC_STEP;
					mar_en = 1'b1;
					mar_val = program_counter + `IPS_PC_STEP;
					iss_kind = RD_ISTREAM;
				end
				next_step = ST_EXEC; // see RULE_04
				next_exec_left = cur_len;
			end
			ST_BR1: begin
				// Target into the address register; sequential word still comes
				arrival_used = 1'b1;
				next_alu = arr_word;
				next_kaddr = opaddr;
				mar_en = 1'b1;
				mar_val = opaddr; // see RULE_19
				iss_kind = RD_ISTREAM;
				next_step = ST_BR2;
			end
			ST_BR2: begin
				mar_en = 1'b1;
				iss_kind = RD_ISTREAM;
				next_step = ST_DECODE; // see RULE_21
				if (taken) begin
					// Sequential word and its address are thrown away
					arrival_used = 1'b1; // see RULE_17
					next_lat_valid = 1'b0;
					next_flush = 1'b1;
					next_pc = target_k + `IPS_PC_STEP; // see RULE_20
					mar_val = target_k + `IPS_PC_STEP;
				end else begin
					// Target read in flight is useless, cancel it
					drop_inflight = 1'b1;
					next_pc = program_counter + `IPS_PC_STEP; // see RULE_20
					mar_val = program_counter + `IPS_PC_STEP;
				end
			end
			ST_EXEC: begin
				// Long execute stalls; refill read starts one cycle before the end
				if (exec_left > `IPS_EXEC_ONE) begin
					next_exec_left = exec_left - 3'h1; // see RULE_10
				end
				if (exec_left == `IPS_EXEC_TWO) begin
					next_pc = program_counter + `IPS_PC_STEP; // see RULE_16
					mar_en = 1'b1;
					mar_val = program_counter + `IPS_PC_STEP;
					iss_kind = RD_ISTREAM;
				end
			end
			default: begin
				next_step = step;
			end
		endcase
		if (do_decode) begin
			if (irq_req) begin
				// Interrupt blocks decode and flushes two pending steps
				next_psw_pc = program_counter - `IPS_IRQ_BACKUP; // see RULE_25
				next_irq_ack = 1'b1;
				next_flush = 1'b1;
				next_pc = irq_vector - `IPS_PC_STEP;
				next_lat_valid = 1'b0;
				arrival_used = 1'b1;
				drop_inflight = 1'b1;
				next_step = ST_FIA;
			end else if (dec_take) begin
				// Execute current, decode next, fetch and address beyond
				arrival_used = !lat_valid;
				next_lat_valid = 1'b0;
				next_micro_addr = dec.start;
				next_micro_valid = 1'b1;
				next_index_sel = dec.index;
				next_cur_mask = dec.mask;
				next_cur_len = dec.exec_len;
				if (dec.fmt == FMT_RX) begin
					next_step = ST_OPADDR; // see RULE_04
				end else if (dec.fmt == FMT_BRANCH) begin
					next_step = ST_BR1;
				end else begin
					next_step = ST_EXEC; // see RULE_03
					next_exec_left = dec.exec_len;
				end
				// Stall holds the address register until refill
				if (dec.fmt == FMT_RX || dec.fmt == FMT_BRANCH
					|| dec.exec_len == `IPS_EXEC_ONE) begin
					next_pc = program_counter + `IPS_PC_STEP; // see RULE_12
					mar_en = 1'b1;
					mar_val = program_counter + `IPS_PC_STEP;
					iss_kind = RD_ISTREAM; // see RULE_13
				end
			end else begin
				// No word ready: leave a bubble rather than re-execute
				next_step = ST_DECODE;
			end
		end
		// Unclaimed instruction words wait in the decode data latch
		if (arr_kind == RD_ISTREAM && !arrival_used) begin
			next_lat = arr_word;
			next_lat_valid = 1'b1;
		end
		if (arr_kind == RD_OPERAND) begin
			next_alu = arr_word; // see RULE_09
		end
		next_exec_active = (next_step == ST_EXEC);
		next_exec_last = (next_step == ST_EXEC) && (next_exec_left == `IPS_EXEC_ONE);
		next_arr_word = mem_rdata;
		next_arr_kind = drop_inflight ? RD_NONE : inflight;
		next_inflight = issued;
		next_issued = iss_kind;
		next_mem_req.read = (iss_kind != RD_NONE);
		next_mem_req.addr = mar_en ? mar_val : mem_req.addr;
	end

	// Step state moves only at the microcycle tick
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			step <= ST_FIA;
			program_counter <= `IPS_RESET_PC;
			exec_left <= `IPS_EXEC_ONE;
			decode_data_latch <= 16'h0000;
			lat_valid <= 1'b0;
			arr_word <= 16'h0000;
			arr_kind <= RD_NONE;
			inflight <= RD_NONE;
			target_k <= 16'h0000;
			cur_mask <= 4'h0;
			cur_len <= `IPS_EXEC_ONE;
			alu_data_latch <= 16'h0000;
			micro_addr <= 8'h00;
			micro_valid <= 1'b0;
			index_sel <= 4'h0;
			exec_active <= 1'b0;
			exec_last <= 1'b0;
			pipe_flush <= 1'b0;
			irq_ack <= 1'b0;
			psw_pc <= 16'h0000;
		end else if (tick) begin
			step <= next_step;
			program_counter <= next_pc;
			exec_left <= next_exec_left;
			decode_data_latch <= next_lat;
			lat_valid <= next_lat_valid;
			arr_word <= next_arr_word;
			arr_kind <= next_arr_kind;
			inflight <= next_inflight;
			target_k <= next_kaddr;
			cur_mask <= next_cur_mask;
			cur_len <= next_cur_len;
			alu_data_latch <= next_alu;
			micro_addr <= next_micro_addr;
			micro_valid <= next_micro_valid;
			index_sel <= next_index_sel;
			exec_active <= next_exec_active;
			exec_last <= next_exec_last;
			pipe_flush <= next_flush;
			irq_ack <= next_irq_ack;
			psw_pc <= next_psw_pc;
		end
	end

	// ----------------------------------------------------------------
	// Address holding register
	// ----------------------------------------------------------------
	// Loaded two clocks before the cycle ends so the bus settles early
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_req <= '0;
			issued <= RD_NONE;
		end else if (mar_load) begin
			mem_req <= next_mem_req; // see RULE_23
			issued <= next_issued;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_cycle_length: assert property (tick |=> !tick [*7] ##1 tick) // see RULE_24
		else $error("microcycle is not eight clocks");
	a_mar_lead_time: assert property ($changed(mem_req) |-> $past(mar_load)) // see RULE_08
		else $error("address register changed outside its load phase");
	a_reset_start: assert property ((tick && step == ST_FIA) |=> step == ST_FILL ##8 step == ST_DECODE) // see RULE_26
		else $error("start-up does not run address, fetch, decode");
	a_pc_advance: assert property ((tick && step == ST_FIA) |=> program_counter == $past(program_counter) + 16'h0002) // see RULE_22
		else $error("program counter not advanced by two");
	a_rr_rate: assert property ((tick && dec_take && dec.fmt == FMT_RR) |=> (step == ST_EXEC && exec_last)) // see RULE_13
		else $error("register instruction not executed next cycle");
	a_rx_flow: assert property ((tick && dec_take && dec.fmt == FMT_RX && dec.exec_len == 3'h1) |=>
		step == ST_OPADDR ##8 step == ST_OPFETCH ##8 (step == ST_EXEC && exec_last)) // see RULE_14
		else $error("indexed instruction flow is not three cycles");
	a_opaddr_load: assert property ((mar_load && step == ST_OPADDR) |=>
		(mem_req.addr == $past(opaddr) && mem_req.read)) // see RULE_07
		else $error("operand address not loaded");
	a_stall_quiet: assert property ((mar_load && step == ST_EXEC && exec_left > 3'h2) |=> !mem_req.read) // see RULE_16
		else $error("read issued during execute stall");
	a_no_early_decode: assert property (dec_take |-> !(step == ST_EXEC && exec_left != 3'h1)) // see RULE_15
		else $error("decode before last execute cycle");
	a_branch_flush: assert property ((tick && step == ST_BR2 && taken) |=>
		(!lat_valid && pipe_flush && program_counter == $past(target_k) + 16'h0002)) // see RULE_17
		else $error("taken branch did not flush");
	a_irq_backup: assert property ((tick && do_decode && irq_req) |=>
		(irq_ack && psw_pc == $past(program_counter) - 16'h0004 && step == ST_FIA)) // see RULE_25
		else $error("interrupt entry saved wrong address");

endmodule

`default_nettype wire

/* File: test/ips_mem_model.sv */
// Behavioural single-cycle main memory facing the pipeline sequencer
`default_nettype none

module ips_mem_model import ips_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Read request and pacing
	input wire ips_mem_req_s mem_req,
	input wire logic slow,
	// Read data
	output logic [15:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] mem [0:511];
	logic [2:0] cnt;
	logic busy;
	logic [15:0] word;

	// ----------------------------------------------------------------
	// Read engine
	// ----------------------------------------------------------------
	// Request taken at the tick, served during the following microcycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 3'h0;
			busy <= 1'b0;
			word <= 16'h0000;
		end else begin
			cnt <= cnt + 3'h1;
			if (cnt == 3'h7) begin
				busy <= mem_req.read;
				word <= mem[mem_req.addr[9:1]];
			end
		end
	end

	// Stale or idle bus shows the inverse, so an early sample never matches
	assign mem_rdata = (busy && cnt >= (slow ? 3'h6 : 3'h1)) ? word : ~word;
endmodule

`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the instruction pipeline sequencer
`default_nettype none

module tb import ips_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic sys_clk;
	logic reset_n;
	logic slow;
	logic [15:0] mem_rdata;
	logic [15:0] index_data;
	logic [3:0] cond_flags;
	logic irq_req;
	logic [15:0] irq_vector;
	ips_mem_req_s mem_req;
	ips_step_e step;
	logic exec_active;
	logic exec_last;
	logic [7:0] micro_addr;
	logic micro_valid;
	logic [3:0] index_sel;
	logic [15:0] alu_data_latch;
	logic pipe_flush;
	logic irq_ack;
	logic [15:0] psw_pc;
	int n_fail;
	int checked;

	ips_sequencer u_ips_sequencer (
		.sys_clk(sys_clk), .reset_n(reset_n), .mem_rdata(mem_rdata),
		.index_data(index_data), .cond_flags(cond_flags), .irq_req(irq_req),
		.irq_vector(irq_vector), .mem_req(mem_req), .step(step),
		.exec_active(exec_active), .exec_last(exec_last), .micro_addr(micro_addr),
		.micro_valid(micro_valid), .index_sel(index_sel),
		.alu_data_latch(alu_data_latch), .pipe_flush(pipe_flush),
		.irq_ack(irq_ack), .psw_pc(psw_pc)
	);

	ips_mem_model u_ips_mem_model (
		.sys_clk(sys_clk), .reset_n(reset_n), .mem_req(mem_req),
		.slow(slow), .mem_rdata(mem_rdata)
	);

	// ----------------------------------------------------------------
	// Clock and index register stand-in
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Register contents follow the selected index field
	always @(negedge sys_clk) index_data <= {8'h01, index_sel, 4'h0};

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] map_op(input logic [15:0] w);
		return {w[13:8], w[15:14]};
	endfunction

	function automatic logic [15:0] rr_word(input int i);
		return {2'b00, 6'(i), 8'h5A};
	endfunction

	function automatic logic [15:0] rx_word(input int j);
		return {2'b01, 6'(j), 4'h0, 4'(j + 1)};
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One microcycle, sampling mid-cycle where outputs are settled
	task automatic uc();
		repeat (8) @(negedge sys_clk);
	endtask

	task automatic load_rr();
		for (int i = 0; i < 512; i++) u_ips_mem_model.mem[i] = rr_word(i);
	endtask

	// Reset for three cycles, then stop at phase 4 of microcycle 0
	task automatic start();
		@(negedge sys_clk);
		reset_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Back-to-back register instructions with slow memory
	task automatic run_rr();
		load_rr();
		slow = 1'b1;
		start();
		check("read", 16'(mem_req.read), 16'h0000);
		check("step", 16'(step), 16'(ST_FIA));
		for (int k = 1; k < 10; k++) begin
			uc();
			check("addr", mem_req.addr, 16'(2 * k));
			if (k < 3) begin
				check("step", 16'(step), 16'(k == 1 ? ST_FILL : ST_DECODE));
			end else begin
				check("step", 16'(step), 16'(ST_EXEC));
				check("last", 16'(exec_last), 16'h0001);
				check("uaddr", 16'(micro_addr), 16'(map_op(rr_word(k - 2))));
				check("valid", 16'(micro_valid), 16'h0001);
			end
		end
	endtask

	// Indexed-storage stream, prompt memory
	task automatic run_rx();
		logic [15:0] oa;
		load_rr();
		for (int j = 0; j < 4; j++) begin
			oa = {8'h01, 4'(j + 1), 4'h0} + 16'h0020 + 16'(2 * j);
			u_ips_mem_model.mem[1 + 2 * j] = rx_word(j);
			u_ips_mem_model.mem[2 + 2 * j] = 16'h0020 + 16'(2 * j);
			u_ips_mem_model.mem[oa[9:1]] = 16'hC000 | oa;
		end
		slow = 1'b0;
		start();
		repeat (3) uc();
		for (int j = 0; j < 3; j++) begin
			// Operand word of the previous instruction lands in the latch at its execute end
			if (j > 0) check("oper", alu_data_latch, 16'hC000 | oa);
			oa = {8'h01, 4'(j + 1), 4'h0} + 16'h0020 + 16'(2 * j);
			check("step", 16'(step), 16'(ST_OPADDR));
			check("uaddr", 16'(micro_addr), 16'(map_op(rx_word(j))));
			check("index", 16'(index_sel), 16'(j + 1));
			uc();
			check("step", 16'(step), 16'(ST_OPFETCH));
			check("addr", mem_req.addr, oa);
			check("disp", alu_data_latch, 16'h0020 + 16'(2 * j));
			uc();
			check("step", 16'(step), 16'(ST_EXEC));
			uc();
		end
		check("oper", alu_data_latch, 16'hC000 | oa);
	endtask

	// Long execute of every length code
	task automatic run_io(input int n);
		int len;
		len = (n == 0) ? 1 : n;
		load_rr();
		u_ips_mem_model.mem[1] = {2'b11, 3'b000, 3'(n), 8'h21};
		slow = 1'b1;
		start();
		repeat (3) uc();
		for (int k = 1; k <= len; k++) begin
			check("step", 16'(step), 16'(ST_EXEC));
			check("active", 16'(exec_active), 16'h0001);
			check("last", 16'(exec_last), 16'(k == len));
			check("valid", 16'(micro_valid), 16'(k == 1));
			uc();
		end
		check("uaddr", 16'(micro_addr), 16'(map_op(rr_word(2))));
		check("valid", 16'(micro_valid), 16'h0001);
	endtask

	// Conditional branch over every flag pattern
	task automatic run_br(input logic [3:0] f);
		logic tk;
		tk = |(4'b0100 & f);
		load_rr();
		u_ips_mem_model.mem[1] = 16'h9542;
		u_ips_mem_model.mem[2] = 16'h0040;
		cond_flags = f;
		slow = f[0];
		start();
		repeat (3) uc();
		check("step", 16'(step), 16'(ST_BR1));
		uc();
		check("step", 16'(step), 16'(ST_BR2));
		check("addr", mem_req.addr, 16'h0160);
		uc();
		check("step", 16'(step), 16'(ST_DECODE));
		check("addr", mem_req.addr, tk ? 16'h0162 : 16'h0008);
		check("flush", 16'(pipe_flush), 16'(tk));
		uc();
		check("uaddr", 16'(micro_addr), 16'(map_op(rr_word(tk ? 176 : 3))));
	endtask

	// Interrupt blocks decode and restarts at the vector
	task automatic run_irq();
		logic [15:0] a1;
		logic [15:0] a2;
		logic [15:0] s;
		load_rr();
		irq_vector = 16'h0080;
		slow = 1'b1;
		start();
		repeat (3) uc();
		irq_req = 1'b1;
		a1 = mem_req.addr;
		a2 = a1;
		for (int k = 0; k < 6; k++) begin
			uc();
			if (irq_ack === 1'b1) break;
			a2 = a1;
			a1 = mem_req.addr;
		end
		irq_req = 1'b0;
		check("ack", 16'(irq_ack), 16'h0001);
		if (irq_ack !== 1'b1) close_out();
		s = psw_pc + 16'h0004;
		check("flush", 16'(pipe_flush), 16'h0001);
		check("valid", 16'(micro_valid), 16'h0000);
		check("saved", 16'(s == mem_req.addr || s == a1 || s == a2), 16'h0001);
		for (int k = 0; k < 4 && mem_req.addr !== irq_vector; k++) uc();
		check("vector", mem_req.addr, irq_vector);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		n_fail = 0;
		checked = 0;
		reset_n = 1'b0;
		slow = 1'b0;
		index_data = 16'h0000;
		cond_flags = 4'h0;
		irq_req = 1'b0;
		irq_vector = 16'h0000;
		run_rr();
		run_rx();
		for (int n = 0; n < 8; n++) run_io(n);
		for (int f = 0; f < 16; f++) run_br(4'(f));
		run_irq();
		close_out();
	end
endmodule

`default_nettype wire
